// [shared/gpprt_irq_if.sv]
// configuration and status carried between port core and trigger detector
`timescale 1ns/1ps
interface gpprt_irq_if;
    logic [7:0] pin_sync;
    logic [7:0] irq_sense_sel;
    logic [7:0] irq_both_edges;
    logic [7:0] irq_event_polarity;
    logic [7:0] clear_pulse;
    logic [7:0] irq_raw_status;
    modport core (output pin_sync, irq_sense_sel, irq_both_edges, irq_event_polarity,
                  clear_pulse, input irq_raw_status);
    modport det  (input pin_sync, irq_sense_sel, irq_both_edges, irq_event_polarity,
                  clear_pulse, output irq_raw_status);
endinterface : gpprt_irq_if

// [shared/gpprt_pkg.sv]
// constants and types shared by the pin port block
package gpprt_pkg;
    localparam int unsigned NPINS      = 8;
    localparam int unsigned AW         = 12;
    // word offsets are byte addresses; the data register spans 0x000..0x3fc
    localparam logic [11:0] DATA_HI    = 12'h03fc;
    localparam logic [11:0] OFS_DIR    = 12'h0400;
    localparam logic [11:0] OFS_SENSE  = 12'h0404;
    localparam logic [11:0] OFS_BOTH   = 12'h0408;
    localparam logic [11:0] OFS_EVENT  = 12'h040c;
    localparam logic [11:0] OFS_MASK   = 12'h0410;
    localparam logic [11:0] OFS_RAW    = 12'h0414;
    localparam logic [11:0] OFS_MSTAT  = 12'h0418;
    localparam logic [11:0] OFS_CLEAR  = 12'h041c;
    localparam logic [11:0] OFS_ALT    = 12'h0420;
    localparam logic [11:0] OFS_DRV2   = 12'h0500;
    localparam logic [11:0] OFS_DRV4   = 12'h0504;
    localparam logic [11:0] OFS_DRV8   = 12'h0508;
    localparam logic [11:0] OFS_ODR    = 12'h050c;
    localparam logic [11:0] OFS_PUR    = 12'h0510;
    localparam logic [11:0] OFS_PDR    = 12'h0514;
    localparam logic [11:0] OFS_SLR    = 12'h0518;
    localparam logic [11:0] OFS_DEN    = 12'h051c;
    localparam logic [11:0] OFS_ID_LO  = 12'h0fd0;
    localparam logic [11:0] OFS_ID_CELL = 12'h0ff0;
    localparam int unsigned MASK_LSB   = 2;
    localparam logic [7:0]  RST_ZERO   = 8'h00;
    localparam logic [7:0]  RST_ONES   = 8'hff;
    localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
    typedef enum logic [2:0] {
        GPPRT_IDLE = 3'b001,
        GPPRT_RESP = 3'b010,
        GPPRT_DONE = 3'b100
    } gpprt_bus_t;
endpackage : gpprt_pkg

// [src/gpprt_detect.sv]
// per-pin edge and level trigger detection with latched raw status
`timescale 1ns/1ps
module gpprt_detect
    import gpprt_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   srst,
    gpprt_irq_if.det    irq
);
    logic [7:0] prev_q;
    logic [7:0] edge_hit;
    logic [7:0] level_hit;
    logic [7:0] raw_q;
    logic [7:0] rise;
    logic [7:0] fall;

    assign rise = irq.pin_sync & ~prev_q;
    assign fall = ~irq.pin_sync & prev_q;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            edge_hit[i] = irq.irq_both_edges[i] ? (rise[i] | fall[i])
                        : (irq.irq_event_polarity[i] ? rise[i] : fall[i]);
            level_hit[i] = irq.irq_sense_sel[i] & (irq.pin_sync[i] == irq.irq_event_polarity[i]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            prev_q <= RST_ZERO;
        else
            prev_q <= irq.pin_sync;
    end

    // set wins over clear; level pins simply track the live match
    always_ff @(posedge clk)
    begin
        if (srst)
            raw_q <= RST_ZERO;
        else
            for (int i = 0; i < 8; i++)
                if (irq.irq_sense_sel[i])
                    raw_q[i] <= level_hit[i];
                else if (edge_hit[i])
                    raw_q[i] <= 1'b1;
                else if (irq.clear_pulse[i])
                    raw_q[i] <= 1'b0;
    end
    assign irq.irq_raw_status = raw_q;

    property p_edge_latch;
        @(posedge clk) disable iff (srst)
        (edge_hit[0] && !irq.irq_sense_sel[0]) |=> raw_q[0];
    endproperty
    a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

    property p_hold_until_clear;
        @(posedge clk) disable iff (srst)
        (raw_q[1] && !irq.irq_sense_sel[1] && !irq.clear_pulse[1]) |=> raw_q[1];
    endproperty
    a_hold_until_clear: assert property (p_hold_until_clear) else $error("latch dropped");

    property p_level_follow;
        @(posedge clk) disable iff (srst)
        irq.irq_sense_sel[2] |=> (raw_q[2] == (($past(irq.pin_sync[2]))
            == $past(irq.irq_event_polarity[2])));
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level mismatch");
endmodule : gpprt_detect

// [src/gpprt_port.sv]
// eight-pin general purpose port with address-masked data and pin interrupts
// Functional notes
// - address bits 9..2 mask data accesses
// - data register aliased over 256 words
// - masked write bits stay unchanged
// - masked read bits return zero
// - each pin has its own direction
// - direction 1 output; reset clears all
// - outputs read latch, inputs read pin
// - enabled pin conditions ORed to irq
// - edge latched until software clears
// - sense, both-edges, event polarity select trigger
// - mask 1 passes pin to irq
// - raw status shows unmasked conditions too
// - masked status is raw and mask
// - clear register: one clears, zero ignored
// - trigger pin drives converter trigger
// - alternate function hands pin to peripheral
// - reset pins are inputs except debug
// - pad controls writable per pin
// - read-only identification registers
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module gpprt_port
    import gpprt_pkg::*;
#(
    parameter logic [7:0] ALT_RESET      = 8'h00,
    parameter int         TRIG_PIN       = 4,
    parameter logic       TRIG_EN        = 1'b1,
    // identification values are arbitrary
    parameter logic [7:0] periph_identification = 8'h5a,
    parameter logic [7:0] cell_identification   = 8'ha5
)
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [AW-1:0]     avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [7:0]        pin_in,
    output logic [7:0]             pin_out,
    output logic [7:0]             pin_oe,
    input  wire logic [7:0]        periph_out,
    input  wire logic [7:0]        periph_oe,
    output logic [7:0]             periph_in,
    output logic [7:0]             pad_drive_low,
    output logic [7:0]             pad_drive_mid,
    output logic [7:0]             pad_drive_high,
    output logic [7:0]             pad_open_drain,
    output logic [7:0]             pad_pull_up,
    output logic [7:0]             pad_pull_down,
    output logic [7:0]             pad_slew,
    output logic [7:0]             pad_digital_en,
    output logic                   port_irq,
    output logic                   converter_trigger
);
    gpprt_irq_if irq ();

    logic [7:0] sync1_q, sync2_q;
    logic [7:0] pin_data_reg_q, pin_direction_q, alt_function_select_q;
    logic [7:0] irq_sense_sel_q, irq_both_edges_q, irq_event_polarity_q, irq_mask_q;
    logic [7:0] drive_low_sel_q, drive_mid_sel_q, drive_high_sel_q, open_drain_sel_q;
    logic [7:0] pull_up_sel_q, pull_down_sel_q, slew_control_sel_q, digital_enable_q;
    logic [7:0] clear_q;
    logic [7:0] masked_stat;
    logic [7:0] data_view;
    logic [7:0] acc_mask;
    logic [31:0] rdata_d;
    logic        is_data;
    logic        wr_go, rd_go;
    gpprt_bus_t  bus_q;

    function automatic logic [7:0] addr_mask(input logic [AW-1:0] a);
        addr_mask = a[MASK_LSB +: 8];
    endfunction : addr_mask

    function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] nv,
                                          input logic [7:0] m);
        wmerge = (old & ~m) | (nv & m);
    endfunction : wmerge

    assign is_data  = (avs_address <= DATA_HI);
    assign acc_mask = addr_mask(avs_address);
    assign wr_go = (bus_q == GPPRT_IDLE) && avs_write && avs_byteenable[0];
    assign rd_go = (bus_q == GPPRT_IDLE) && avs_read;

    // two-stage synchroniser; only the second stage is read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_q <= RST_ZERO;
            sync2_q <= RST_ZERO;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // one-cycle wait then answer: requests are taken in IDLE, answered in RESP
    always_ff @(posedge clk)
    begin
        if (srst)
            bus_q <= GPPRT_IDLE;
        else
            case (bus_q)
                GPPRT_IDLE: if (avs_read || avs_write) bus_q <= GPPRT_RESP;
                GPPRT_RESP: bus_q <= GPPRT_DONE;
                GPPRT_DONE: bus_q <= GPPRT_IDLE;
                default:    bus_q <= GPPRT_IDLE;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(bus_q == GPPRT_IDLE && (avs_read || avs_write));
    end

    // writes to input pins are dropped; only bits of output pins update the latch
    always_ff @(posedge clk)
    begin
        if (srst)
            pin_data_reg_q <= RST_ZERO;
        else if (wr_go && is_data)
            pin_data_reg_q <= wmerge(pin_data_reg_q, avs_writedata[7:0],
                                     acc_mask & pin_direction_q);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_direction_q       <= RST_ZERO;
            alt_function_select_q <= ALT_RESET;
            irq_sense_sel_q       <= RST_ZERO;
            irq_both_edges_q      <= RST_ZERO;
            irq_event_polarity_q  <= RST_ZERO;
            irq_mask_q            <= RST_ZERO;
            drive_low_sel_q       <= RST_ONES;
            drive_mid_sel_q       <= RST_ZERO;
            drive_high_sel_q      <= RST_ZERO;
            open_drain_sel_q      <= RST_ZERO;
            pull_up_sel_q         <= RST_ONES;
            pull_down_sel_q       <= RST_ZERO;
            slew_control_sel_q    <= RST_ZERO;
            digital_enable_q      <= RST_ONES;
        end
        else if (wr_go)
            case (avs_address)
                OFS_DIR:   pin_direction_q       <= avs_writedata[7:0];
                OFS_SENSE: irq_sense_sel_q       <= avs_writedata[7:0];
                OFS_BOTH:  irq_both_edges_q      <= avs_writedata[7:0];
                OFS_EVENT: irq_event_polarity_q  <= avs_writedata[7:0];
                OFS_MASK:  irq_mask_q            <= avs_writedata[7:0];
                OFS_ALT:   alt_function_select_q <= avs_writedata[7:0];
                OFS_DRV2:  drive_low_sel_q       <= avs_writedata[7:0];
                OFS_DRV4:  drive_mid_sel_q       <= avs_writedata[7:0];
                OFS_DRV8:  drive_high_sel_q      <= avs_writedata[7:0];
                OFS_ODR:   open_drain_sel_q      <= avs_writedata[7:0];
                OFS_PUR:   pull_up_sel_q         <= avs_writedata[7:0];
                OFS_PDR:   pull_down_sel_q       <= avs_writedata[7:0];
                OFS_SLR:   slew_control_sel_q    <= avs_writedata[7:0];
                OFS_DEN:   digital_enable_q      <= avs_writedata[7:0];
                default:   ;
            endcase
    end

    // one-cycle clear strobe toward the detector
    always_ff @(posedge clk)
    begin
        if (srst)
            clear_q <= RST_ZERO;
        else if (wr_go && avs_address == OFS_CLEAR)
            clear_q <= avs_writedata[7:0];
        else
            clear_q <= RST_ZERO;
    end

    assign irq.pin_sync           = sync2_q & digital_enable_q;
    assign irq.irq_sense_sel      = irq_sense_sel_q;
    assign irq.irq_both_edges     = irq_both_edges_q;
    assign irq.irq_event_polarity = irq_event_polarity_q;
    assign irq.clear_pulse        = clear_q;

    gpprt_detect u_detect (
        .clk  (clk),
        .srst (srst),
        .irq  (irq)
    );

    assign masked_stat = irq.irq_raw_status & irq_mask_q;
    assign data_view = (pin_data_reg_q & pin_direction_q)
                     | (irq.pin_sync & ~pin_direction_q);

    always_comb
    begin
        rdata_d = UNMAPPED;
        if (is_data)
            rdata_d = {24'h00_0000, data_view & acc_mask};
        else if (avs_address >= OFS_ID_CELL)
            rdata_d = {24'h00_0000, cell_identification};
        else if (avs_address >= OFS_ID_LO)
            rdata_d = {24'h00_0000, periph_identification};
        else
            case (avs_address)
                OFS_DIR:   rdata_d[7:0] = pin_direction_q;
                OFS_SENSE: rdata_d[7:0] = irq_sense_sel_q;
                OFS_BOTH:  rdata_d[7:0] = irq_both_edges_q;
                OFS_EVENT: rdata_d[7:0] = irq_event_polarity_q;
                OFS_MASK:  rdata_d[7:0] = irq_mask_q;
                OFS_RAW:   rdata_d[7:0] = irq.irq_raw_status;
                OFS_MSTAT: rdata_d[7:0] = masked_stat;
                OFS_ALT:   rdata_d[7:0] = alt_function_select_q;
                OFS_DRV2:  rdata_d[7:0] = drive_low_sel_q;
                OFS_DRV4:  rdata_d[7:0] = drive_mid_sel_q;
                OFS_DRV8:  rdata_d[7:0] = drive_high_sel_q;
                OFS_ODR:   rdata_d[7:0] = open_drain_sel_q;
                OFS_PUR:   rdata_d[7:0] = pull_up_sel_q;
                OFS_PDR:   rdata_d[7:0] = pull_down_sel_q;
                OFS_SLR:   rdata_d[7:0] = slew_control_sel_q;
                OFS_DEN:   rdata_d[7:0] = digital_enable_q;
                default:   rdata_d = UNMAPPED;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            avs_readdata <= UNMAPPED;
        else if (rd_go)
            avs_readdata <= rdata_d;
    end

    // pin steering: peripheral owns the pad when its select bit is set
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_out   <= RST_ZERO;
            pin_oe    <= RST_ZERO;
            periph_in <= RST_ZERO;
        end
        else
        begin
            pin_out   <= (alt_function_select_q & periph_out)
                       | (~alt_function_select_q & pin_data_reg_q);
            pin_oe    <= (alt_function_select_q & periph_oe)
                       | (~alt_function_select_q & pin_direction_q);
            periph_in <= sync2_q & alt_function_select_q & digital_enable_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pad_drive_low  <= RST_ONES;
            pad_drive_mid  <= RST_ZERO;
            pad_drive_high <= RST_ZERO;
            pad_open_drain <= RST_ZERO;
            pad_pull_up    <= RST_ONES;
            pad_pull_down  <= RST_ZERO;
            pad_slew       <= RST_ZERO;
            pad_digital_en <= RST_ONES;
        end
        else
        begin
            pad_drive_low  <= drive_low_sel_q;
            pad_drive_mid  <= drive_mid_sel_q;
            pad_drive_high <= drive_high_sel_q;
            pad_open_drain <= open_drain_sel_q;
            pad_pull_up    <= pull_up_sel_q;
            pad_pull_down  <= pull_down_sel_q;
            pad_slew       <= slew_control_sel_q;
            pad_digital_en <= digital_enable_q;
        end
    end

    // level sources must hold until serviced; no latching is done for them
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            port_irq          <= 1'b0;
            converter_trigger <= 1'b0;
        end
        else
        begin
            port_irq          <= |masked_stat;
            converter_trigger <= TRIG_EN && masked_stat[TRIG_PIN];
        end
    end

    property p_irq_or;
        @(posedge clk) disable iff (srst)
        1'b1 |=> port_irq == $past(|(irq.irq_raw_status & irq_mask_q));
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not OR of masked");

    property p_mask_blocks;
        @(posedge clk) disable iff (srst)
        (irq_mask_q == 8'h00) |=> !port_irq;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq leaked");

    property p_masked_write;
        @(posedge clk) disable iff (srst)
        (wr_go && is_data && acc_mask == 8'h00) |=> $stable(pin_data_reg_q);
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("masked write changed");

    property p_read_mask;
        @(posedge clk) disable iff (srst)
        (rd_go && is_data) |=> ((avs_readdata[7:0] & ~$past(acc_mask)) == 8'h00);
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("masked read bit set");

    property p_alt_pin;
        @(posedge clk) disable iff (srst)
        (alt_function_select_q[0] && $stable(periph_oe[0]) && $stable(alt_function_select_q[0]))
            |=> pin_oe[0] == $past(periph_oe[0]);
    endproperty
    a_alt_pin: assert property (p_alt_pin) else $error("alt pin not handed over");

    property p_trig;
        @(posedge clk) disable iff (srst)
        (irq_mask_q[TRIG_PIN] && irq.irq_raw_status[TRIG_PIN] && TRIG_EN) |=> converter_trigger;
    endproperty
    a_trig: assert property (p_trig) else $error("converter trigger missing");

    property p_answer;
        @(posedge clk) disable iff (srst)
        (bus_q == GPPRT_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing");

    property p_dir_reset;
        @(posedge clk) srst |=> (pin_direction_q == RST_ZERO && pin_oe == RST_ZERO);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not reset");
endmodule : gpprt_port

// [tb/gpprt_pins.sv]
// pad-side partner: resolves each pin from the port drive and an outside source
`timescale 1ns/1ps
module gpprt_pins
(
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_in
);
    // the outside source holds its level until the bench has read the status back
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpprt_pins

// [tb/testbench.sv]
// self-checking bench for the pin port: register model, masked data and pin interrupts
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench
    import gpprt_pkg::*;
;
    localparam logic [11:0] reg_ofs [14] = '{OFS_DIR, OFS_SENSE, OFS_BOTH, OFS_EVENT, OFS_MASK,
        OFS_ALT, OFS_DRV2, OFS_DRV4, OFS_DRV8, OFS_ODR, OFS_PUR, OFS_PDR, OFS_SLR, OFS_DEN};
    localparam logic [7:0]  reg_rst [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};
    logic        clk            = 1'b0;
    logic        srst           = 1'b1;
    logic [11:0] avs_address    = 12'h000;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pin_in, pin_out, pin_oe, ext_level = 8'h00;
    logic [7:0]  periph_out = 8'h00, periph_oe = 8'h00;
    logic [7:0]  periph_in;
    logic [7:0]  pdl, pdm, pdh, pod, ppu, ppd, psl, pde;
    logic [63:0] pads;
    logic        port_irq, converter_trigger;
    int          error_cnt       = 0;
    int          samples_checked = 0;
    logic [31:0] seed = 32'h4cd3_ee0b;
    logic [31:0] rd;
    logic [7:0]  cfg [14];
    logic [7:0]  data_q = 8'h00;
    logic [7:0]  a, b, c, m, d, mk, raw, eg, lv, oe, po;

    assign pads = {pdl, pdm, pdh, pod, ppu, ppd, psl, pde};
    // the port clock runs from time zero, well before the first access
    always #2.5 clk = ~clk;

    gpprt_port #(
        // identification values are arbitrary
        .periph_identification (8'h3c),
        .cell_identification   (8'hc3)
    ) DUT (
        .clk               (clk),
        .srst              (srst),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_byteenable    (avs_byteenable),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .pin_in            (pin_in),
        .pin_out           (pin_out),
        .pin_oe            (pin_oe),
        .periph_out        (periph_out),
        .periph_oe         (periph_oe),
        .periph_in         (periph_in),
        .pad_drive_low     (pdl),
        .pad_drive_mid     (pdm),
        .pad_drive_high    (pdh),
        .pad_open_drain    (pod),
        .pad_pull_up       (ppu),
        .pad_pull_down     (ppd),
        .pad_slew          (psl),
        .pad_digital_en    (pde),
        .port_irq          (port_irq),
        .converter_trigger (converter_trigger)
    );

    gpprt_pins pins (
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .ext_level (ext_level),
        .pin_in    (pin_in)
    );

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8

    // holds the request until waitrequest is seen low, then leaves one idle cycle
    task automatic bus(input logic wr, input logic [11:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address   <= adr;
        avs_writedata <= {24'h00_0000, wd};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64)
            `CHK(1'b0, 1'b1)
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic pins_chk();
        oe = (cfg[5] & periph_oe) | (~cfg[5] & cfg[0]);
        po = (cfg[5] & periph_out) | (~cfg[5] & data_q);
        `CHK(pin_oe, oe)
        `CHK(pin_out & oe, po & oe)
    endtask : pins_chk

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK({pin_oe, port_irq, converter_trigger}, 10'h000)
        `CHK(pads, 64'hff00_0000_ff00_00ff)
        foreach (reg_ofs[i])
        begin
            bus(1'b0, reg_ofs[i], 8'h00);
            `CHK(rd, {24'h00_0000, reg_rst[i]})
            cfg[i] = reg_rst[i];
        end
        bus(1'b1, OFS_ID_LO, 8'hff);
        bus(1'b0, OFS_ID_LO, 8'h00);
        `CHK(rd, 32'h0000_003c)
        bus(1'b0, 12'hff0, 8'h00);
        `CHK(rd, 32'h0000_00c3)
        bus(1'b1, 12'h600, 8'hff);
        bus(1'b0, 12'h600, 8'h00);
        `CHK(rd, 32'h0000_0000)
        repeat (3)
            foreach (reg_ofs[i])
            begin
                cfg[i] = rnd8();
                bus(1'b1, reg_ofs[i], cfg[i]);
                bus(1'b0, reg_ofs[i], 8'h00);
                `CHK(rd, {24'h00_0000, cfg[i]})
            end
        `CHK(pads, {cfg[6], cfg[7], cfg[8], cfg[9], cfg[10], cfg[11], cfg[12], cfg[13]})
        for (int k = 0; k < 24; k++)
        begin
            periph_out <= rnd8();
            periph_oe  <= rnd8();
            ext_level  <= rnd8();
            if (k % 8 == 0)
            begin
                cfg[0] = rnd8();
                cfg[5] = rnd8() & rnd8();
                bus(1'b1, OFS_DIR, cfg[0]);
                bus(1'b1, OFS_ALT, cfg[5]);
            end
            m = (k == 0) ? 8'h26 : rnd8();
            d = (k == 0) ? 8'heb : rnd8();
            bus(1'b1, {2'b00, m, 2'b00}, d);
            data_q = (data_q & ~(m & cfg[0])) | (d & m & cfg[0]);
            pins_chk();
            m = (k == 0) ? 8'h31 : rnd8();
            bus(1'b0, {2'b00, m, 2'b00}, 8'h00);
            lv = (oe & po) | (~oe & ext_level);
            `CHK(rd, {24'h00_0000, m & ((cfg[0] & data_q) | (~cfg[0] & lv & cfg[13]))})
            `CHK(periph_in, lv & cfg[5] & cfg[13])
        end
        cfg[0] = 8'h00;
        cfg[5] = 8'h00;
        bus(1'b1, OFS_DIR, 8'h00);
        bus(1'b1, OFS_ALT, 8'h00);
        for (int k = 0; k < 12; k++)
        begin
            a  = rnd8();
            b  = rnd8();
            mk = rnd8();
            // masked while the trigger setup changes, so set-up glitches never reach irq
            bus(1'b1, OFS_MASK, 8'h00);
            for (int j = 1; j < 4; j++)
            begin
                cfg[j] = rnd8();
                bus(1'b1, reg_ofs[j], cfg[j]);
            end
            ext_level <= a;
            repeat (4) @(posedge clk);
            bus(1'b1, OFS_CLEAR, 8'hff);
            bus(1'b1, OFS_MASK, mk);
            ext_level <= b;
            repeat (6) @(posedge clk);
            // the detector only sees pins whose digital input is enabled
            a   = a & cfg[13];
            b   = b & cfg[13];
            lv  = ~(b ^ cfg[3]);
            eg  = (cfg[2] & (a ^ b)) | (~cfg[2] & cfg[3] & ~a & b) | (~cfg[2] & ~cfg[3] & a & ~b);
            raw = (cfg[1] & lv) | (~cfg[1] & eg);
            bus(1'b0, OFS_RAW, 8'h00);
            `CHK(rd, {24'h00_0000, raw})
            bus(1'b0, OFS_MSTAT, 8'h00);
            `CHK(rd, {24'h00_0000, raw & mk})
            `CHK(port_irq, |(raw & mk))
            `CHK(converter_trigger, raw[4] & mk[4])
            c = rnd8();
            bus(1'b1, OFS_CLEAR, c);
            raw = raw & ~(c & ~cfg[1]);
            bus(1'b0, OFS_RAW, 8'h00);
            `CHK(rd, {24'h00_0000, raw})
            `CHK(port_irq, |(raw & mk))
        end
        tally_and_finish();
    end

    // the whole sequence needs about 1000 cycles; this leaves a wide margin
    initial
    begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : testbench
